// ===== itd_cycle_timer.sv
// cycle sequencer that holds one instruction for its cycle count
`timescale 1ns/1ps
`include "itd_map.svh"
module itd_cycle_timer (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       load,
  input  wire logic [3:0] cycles,
  output logic            busy_r,
  output logic            done_r,
  output logic            ready_r
);
  typedef struct packed {
    itd_pkg::itd_state_t st;
    logic [3:0]          remain;
    logic                busy;
    logic                done;
    logic                ready;
  } itd_tmr_t;

  itd_tmr_t s_r;
  itd_tmr_t s_nxt;

  // ========================================================
  // count down, last cycle marked for back-to-back issue
  always_comb begin
    s_nxt = s_r;
    unique case (s_r.st)
      itd_pkg::ITD_ST_IDLE: s_nxt.remain = 4'h0;
      itd_pkg::ITD_ST_RUN: begin
        s_nxt.remain = s_r.remain - 4'h1;
        if (s_r.remain == 4'h1) s_nxt.st = itd_pkg::ITD_ST_LAST;
      end
      itd_pkg::ITD_ST_LAST: s_nxt.st = itd_pkg::ITD_ST_IDLE;
    endcase
    // a load in the last cycle starts the next one at once
    if (load) begin
      s_nxt.remain = cycles - `ITD_CYC_SINGLE;
      s_nxt.st     = (cycles == `ITD_CYC_SINGLE) ? itd_pkg::ITD_ST_LAST
                                                 : itd_pkg::ITD_ST_RUN;
    end
    s_nxt.busy  = (s_nxt.st != itd_pkg::ITD_ST_IDLE);
    s_nxt.done  = (s_nxt.st == itd_pkg::ITD_ST_LAST);
    s_nxt.ready = !s_nxt.busy || s_nxt.done;
  end

  // ========================================================
  // state register
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '{st: itd_pkg::ITD_ST_IDLE, remain: 4'h0, busy: 1'b0,
               done: 1'b0, ready: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy_r  = s_r.busy;
  assign done_r  = s_r.done;
  assign ready_r = s_r.ready;
endmodule : itd_cycle_timer

// ===== itd_decoder.sv
// instruction length, cycle timing and branch decode for the core
`timescale 1ns/1ps
`include "itd_map.svh"
module itd_decoder (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        instr_valid,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand1,
  input  wire logic [7:0]  operand2,
  input  wire logic [15:0] instr_pc,
  input  wire logic [7:0]  acc,
  input  wire logic [15:0] data_pointer_16,
  input  wire logic [15:0] return_addr,
  input  wire logic        cond_true,
  output logic             issue_ready,
  output logic             exec_busy,
  output logic             exec_done,
  output logic [1:0]       instr_len,
  output logic [3:0]       instr_cycles,
  output logic [15:0]      next_pc,
  output logic             redirect,
  output logic [15:0]      redirect_target,
  output logic             nop_alias
);
  typedef struct packed {
    logic [1:0]  len;
    logic [3:0]  cyc;
    logic [15:0] npc;
    logic        redir;
    logic [15:0] tgt;
    logic        nop_al;
  } itd_core_t;

  itd_core_t          s_r;
  itd_core_t          s_nxt;
  itd_pkg::itd_dec_t  dec;
  logic               issue;
  logic               taken;
  logic [3:0]         cyc_total;
  logic [15:0]        calc_npc;
  logic [15:0]        calc_tgt;
  logic               tmr_ready;

  // ========================================================
  // opcode table: bytes, base cycles, condition, destination
  always_comb begin
    dec = '{len: `ITD_LEN_1B, cyc: `ITD_CYC_SINGLE, cond: 1'b0,
            tsel: itd_pkg::ITD_TS_NONE};
    unique casez (opcode)
      // RQ1 register source one cycle, two byte register moves two cycles
      8'b0000_1???, 8'b0001_1???, 8'b0010_1???, 8'b0011_1???,
      8'b0100_1???, 8'b0101_1???, 8'b0110_1???, 8'b1001_1???,
      8'b1100_1???, 8'b1110_1???, 8'b1111_1???: begin
        dec.len = `ITD_LEN_1B;
        dec.cyc = `ITD_CYC_SINGLE;
      end
      8'b0111_1???, 8'b1000_1???, 8'b1010_1???: begin
        dec.len = `ITD_LEN_2B;
        dec.cyc = `ITD_CYC_DOUBLE;
      end
      // RQ18 compare register jump
      8'b1011_1???: begin
        dec = '{`ITD_LEN_3B, `ITD_CYC_TRIPLE, 1'b1,
                itd_pkg::ITD_TS_REL2};
      end
      // RQ20 decrement register jump
      8'b1101_1???: begin
        dec = '{`ITD_LEN_2B, `ITD_CYC_DOUBLE, 1'b1,
                itd_pkg::ITD_TS_REL1};
      end
      // RQ3 RQ12 pointer indirect two cycles
      8'b0000_011?, 8'b0001_011?, 8'b0010_011?, 8'b0011_011?,
      8'b0100_011?, 8'b0101_011?, 8'b0110_011?, 8'b1001_011?,
      8'b1100_011?, 8'b1101_011?, 8'b1110_011?, 8'b1111_011?: begin
        dec.len = `ITD_LEN_1B;
        dec.cyc = `ITD_CYC_DOUBLE;
      end
      8'b0111_011?, 8'b1000_011?, 8'b1010_011?: begin
        dec.len = `ITD_LEN_2B;
        dec.cyc = `ITD_CYC_DOUBLE;
      end
      // RQ19 compare indirect jump
      8'b1011_011?: begin
        dec = '{`ITD_LEN_3B, `ITD_CYC_CJNE_IND, 1'b1,
                itd_pkg::ITD_TS_REL2};
      end
      // RQ2 direct or immediate source two cycles
      8'h05, 8'h15, 8'h25, 8'h35, 8'h45, 8'h55, 8'h65, 8'h95,
      8'hc5, 8'he5, 8'hf5, 8'h24, 8'h34, 8'h44, 8'h54, 8'h64,
      8'h74, 8'h94: begin
        dec.len = `ITD_LEN_2B;
        dec.cyc = `ITD_CYC_DOUBLE;
      end
      // RQ7 RQ4 RQ8 three byte moves and logic
      8'h75, 8'h85, 8'h43, 8'h53, 8'h63, 8'h90: begin
        dec.len = `ITD_LEN_3B;
        dec.cyc = `ITD_CYC_TRIPLE;
      end
      // RQ24 unused opcode as no operation
      `ITD_OP_UNUSED, `ITD_OP_NOP: begin
        dec.len = `ITD_LEN_1B;
        dec.cyc = `ITD_CYC_SINGLE;
      end
      // RQ15 RQ20 three byte conditional jumps
      8'hb5, 8'hd5, 8'hb4, 8'h10, 8'h20, 8'h30: begin
        dec = '{`ITD_LEN_3B, `ITD_CYC_TRIPLE, 1'b1,
                itd_pkg::ITD_TS_REL2};
      end
      // RQ6 accumulator only
      8'h04, 8'h14, 8'hc4, 8'hd4, 8'he4, 8'hf4, 8'h03, 8'h13,
      8'h23, 8'h33, 8'ha3, 8'hb3, 8'hc3, 8'hd3: begin
        dec.len = `ITD_LEN_1B;
        dec.cyc = `ITD_CYC_SINGLE;
      end
      // RQ21 multiply and divide
      `ITD_OP_MUL: dec.cyc = `ITD_CYC_MUL;
      `ITD_OP_DIV: dec.cyc = `ITD_CYC_DIV;
      // RQ17 jump through pointer
      8'h73: begin
        dec.cyc  = `ITD_CYC_TRIPLE;
        dec.tsel = itd_pkg::ITD_TS_ACC_DATA_POINTER_16;
      end
      // RQ9 RQ10 code reads and external data
      8'h83, 8'h93, 8'b111?_001?, 8'b111?_0000: begin
        dec.len = `ITD_LEN_1B;
        dec.cyc = `ITD_CYC_TRIPLE;
      end
      // RQ22 long jump and call, then the returns
      8'h02, 8'h12: begin
        dec = '{`ITD_LEN_3B, `ITD_CYC_LONG, 1'b0,
                itd_pkg::ITD_TS_LONG};
      end
      8'h22, 8'h32: begin
        dec = '{`ITD_LEN_1B, `ITD_CYC_RET, 1'b0,
                itd_pkg::ITD_TS_RET};
      end
      // RQ5 RQ11 RQ13 two byte bit and direct forms
      8'h42, 8'h52, 8'h62, 8'h72, 8'h82, 8'h92, 8'ha2, 8'hb2,
      8'hc2, 8'hd2, 8'ha0, 8'hb0, 8'hc0, 8'hd0: begin
        dec.len = `ITD_LEN_2B;
        dec.cyc = `ITD_CYC_DOUBLE;
      end
      // RQ22 RQ25 absolute page jump and call
      8'b???_?_0001: begin
        dec = '{`ITD_LEN_2B, `ITD_CYC_TRIPLE, 1'b0,
                itd_pkg::ITD_TS_PAGE};
      end
      // RQ14 carry and zero jumps
      8'h40, 8'h50, 8'h60, 8'h70: begin
        dec = '{`ITD_LEN_2B, `ITD_CYC_DOUBLE, 1'b1,
                itd_pkg::ITD_TS_REL1};
      end
      // RQ16 short jump
      8'h80: begin
        dec = '{`ITD_LEN_2B, `ITD_CYC_TRIPLE, 1'b0,
                itd_pkg::ITD_TS_REL1};
      end
    endcase
  end

  // ========================================================
  // a taken conditional branch costs one cycle more
  assign issue     = instr_valid && tmr_ready;
  assign taken     = dec.cond ? cond_true
                              : (dec.tsel != itd_pkg::ITD_TS_NONE);
  assign cyc_total = dec.cyc + ((dec.cond && cond_true) ?
                                `ITD_CYC_TAKEN : 4'h0);

  itd_target_calc u_tgt (
    .instr_pc        (instr_pc),
    .len             (dec.len),
    .tsel            (dec.tsel),
    .opcode          (opcode),
    .operand1        (operand1),
    .operand2        (operand2),
    .acc             (acc),
    .data_pointer_16 (data_pointer_16),
    .return_addr     (return_addr),
    .next_pc         (calc_npc),
    .target          (calc_tgt)
  );

  itd_cycle_timer u_tmr (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .load    (issue),
    .cycles  (cyc_total),
    .busy_r  (exec_busy),
    .done_r  (exec_done),
    .ready_r (tmr_ready)
  );

  // ========================================================
  // results captured at issue and held until the next issue
  always_comb begin
    s_nxt = s_r;
    if (issue) begin
      s_nxt.len    = dec.len;
      s_nxt.cyc    = cyc_total;
      s_nxt.npc    = calc_npc;
      s_nxt.redir  = taken;
      s_nxt.tgt    = taken ? calc_tgt : calc_npc;
      s_nxt.nop_al = (opcode == `ITD_OP_UNUSED);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign issue_ready     = tmr_ready;
  assign instr_len       = s_r.len;
  assign instr_cycles    = s_r.cyc;
  assign next_pc         = s_r.npc;
  assign redirect        = s_r.redir;
  assign redirect_target = s_r.tgt;
  assign nop_alias       = s_r.nop_al;

  // ========================================================
  // checks on decode and timing
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_rq1;
    issue && (opcode ==? 8'b00?0_1??? || opcode ==? 8'b1001_1???)
      |=> instr_len == `ITD_LEN_1B && instr_cycles == `ITD_CYC_SINGLE;
  endproperty
  a_rq1: assert property (p_rq1) // RQ1
    else $error("register arithmetic timing wrong");
  property p_rq2;
    issue && (opcode == 8'h24 || opcode == 8'h95)
      |=> instr_len == `ITD_LEN_2B ##0 exec_busy && !exec_done
      ##1 exec_done;
  endproperty
  a_rq2: assert property (p_rq2) // RQ2
    else $error("direct arithmetic timing wrong");
  property p_rq3;
    issue && opcode ==? 8'b00?0_011?
      |=> instr_len == `ITD_LEN_1B && instr_cycles == `ITD_CYC_DOUBLE;
  endproperty
  a_rq3: assert property (p_rq3) // RQ3
    else $error("indirect arithmetic timing wrong");
  property p_rq4;
    issue && (opcode == 8'h43 || opcode == 8'h53 || opcode == 8'h63)
      |=> instr_len == `ITD_LEN_3B ##0 (!exec_done)[*2] ##1 exec_done;
  endproperty
  a_rq4: assert property (p_rq4) // RQ4
    else $error("logic immediate to direct timing wrong");
  property p_rq5;
    issue && (opcode == 8'h42 || opcode == 8'h52 || opcode == 8'h62)
      |=> instr_len == `ITD_LEN_2B && instr_cycles == `ITD_CYC_DOUBLE;
  endproperty
  a_rq5: assert property (p_rq5) // RQ5
    else $error("logic accumulator to direct timing wrong");
  property p_rq6;
    issue && (opcode == 8'he4 || opcode == 8'hc4 || opcode == 8'h33)
      |=> exec_done && instr_len == `ITD_LEN_1B;
  endproperty
  a_rq6: assert property (p_rq6) // RQ6
    else $error("accumulator operation not single cycle");
  property p_rq7;
    issue && (opcode == 8'h85 || opcode == 8'h90)
      |=> instr_len == `ITD_LEN_3B && instr_cycles == `ITD_CYC_TRIPLE;
  endproperty
  a_rq7: assert property (p_rq7) // RQ7 RQ8
    else $error("three byte move timing wrong");
  property p_rq10;
    issue && (opcode ==? 8'b111?_001? || opcode ==? 8'b111?_0000 ||
              opcode == 8'h83 || opcode == 8'h93)
      |=> instr_len == `ITD_LEN_1B ##0 (!exec_done)[*2] ##1 exec_done;
  endproperty
  a_rq10: assert property (p_rq10) // RQ9 RQ10
    else $error("code or external data timing wrong");
  property p_rq11;
    issue && (opcode == 8'hc0 || opcode == 8'hd0 || opcode == 8'h82)
      |=> instr_len == `ITD_LEN_2B && instr_cycles == `ITD_CYC_DOUBLE;
  endproperty
  a_rq11: assert property (p_rq11) // RQ11 RQ13
    else $error("stack or carry bit timing wrong");
  property p_rq12;
    issue && opcode ==? 8'b1101_011?
      |=> instr_len == `ITD_LEN_1B && instr_cycles == `ITD_CYC_DOUBLE;
  endproperty
  a_rq12: assert property (p_rq12) // RQ12
    else $error("nibble exchange timing wrong");
  property p_rq14;
    issue && opcode == 8'h40
      |=> instr_len == `ITD_LEN_2B && redirect == $past(cond_true) &&
          instr_cycles == (`ITD_CYC_DOUBLE + {3'h0, $past(cond_true)});
  endproperty
  a_rq14: assert property (p_rq14) // RQ14
    else $error("carry jump timing wrong");
  property p_rq15;
    issue && opcode == 8'h10 && cond_true
      |=> instr_len == `ITD_LEN_3B ##0 (!exec_done)[*3] ##1 exec_done;
  endproperty
  a_rq15: assert property (p_rq15) // RQ15
    else $error("bit test jump taken timing wrong");
  property p_rq16;
    issue && opcode == 8'h80
      |=> redirect && instr_cycles == `ITD_CYC_TRIPLE &&
          redirect_target == next_pc + {{8{$past(operand1[7])}},
                                         $past(operand1)};
  endproperty
  a_rq16: assert property (p_rq16) // RQ16 RQ23
    else $error("short jump wrong");
  property p_rq17;
    issue && opcode == 8'h73
      |=> redirect && redirect_target ==
          $past(data_pointer_16) + {8'h0, $past(acc)};
  endproperty
  a_rq17: assert property (p_rq17) // RQ17
    else $error("pointer jump target wrong");
  property p_rq18;
    issue && opcode ==? 8'b1011_1??? && !cond_true
      |=> instr_len == `ITD_LEN_3B && !redirect &&
          instr_cycles == `ITD_CYC_TRIPLE;
  endproperty
  a_rq18: assert property (p_rq18) // RQ18
    else $error("compare register jump timing wrong");
  property p_rq19;
    issue && opcode ==? 8'b1011_011? && cond_true
      |=> (!exec_done)[*4] ##1 exec_done;
  endproperty
  a_rq19: assert property (p_rq19) // RQ19
    else $error("compare indirect jump timing wrong");
  property p_rq20;
    issue && opcode == 8'hd5 && cond_true
      |=> instr_len == `ITD_LEN_3B &&
          instr_cycles == `ITD_CYC_TRIPLE + `ITD_CYC_TAKEN;
  endproperty
  a_rq20: assert property (p_rq20) // RQ20
    else $error("decrement direct jump timing wrong");
  property p_rq21;
    issue && opcode == `ITD_OP_DIV
      |=> (!exec_done)[*7] ##1 exec_done;
  endproperty
  a_rq21: assert property (p_rq21) // RQ21
    else $error("divide not eight cycles");
  property p_rq22;
    issue && (opcode == 8'h22 || opcode == 8'h32)
      |=> instr_len == `ITD_LEN_1B && instr_cycles == `ITD_CYC_RET &&
          redirect_target == $past(return_addr);
  endproperty
  a_rq22: assert property (p_rq22) // RQ22
    else $error("return timing wrong");
  property p_rq24;
    issue && opcode == `ITD_OP_UNUSED
      |=> nop_alias && exec_done && !redirect &&
          instr_len == `ITD_LEN_1B;
  endproperty
  a_rq24: assert property (p_rq24) // RQ24
    else $error("unused opcode not a no operation");
  property p_rq25;
    issue && opcode[4:0] == 5'h01
      |=> redirect_target[15:11] == next_pc[15:11] &&
          redirect_target[10:8] == $past(opcode[7:5]);
  endproperty
  a_rq25: assert property (p_rq25) // RQ25
    else $error("page target left its page");

endmodule : itd_decoder

// ===== itd_map.svh
// constants for the instruction length and cycle timing decoder
//
// Functional notes
// RQ1 - register-source add/addc/subb: one byte, one cycle
// RQ2 - direct or immediate accumulator arithmetic: two, two
// RQ3 - pointer-indirect arithmetic, inc, dec: one byte, two
// RQ4 - logic immediate into direct byte: three, three
// RQ5 - logic accumulator into direct byte: two, two
// RQ6 - accumulator-only operations: one byte, one cycle
// RQ7 - direct to direct move: three bytes, three
// RQ8 - load data pointer immediate: three, three
// RQ9 - code byte reads: one byte, three cycles
// RQ10 - every external data move: one byte, three
// RQ11 - push and pop: two bytes, two cycles
// RQ12 - low nibble exchange: one byte, two cycles
// RQ13 - bit and/or into carry: two, two
// RQ14 - carry/zero jumps: two bytes, two or three
// RQ15 - bit test jumps: three bytes, three or four
// RQ16 - short relative jump: two bytes, three cycles
// RQ17 - accumulator plus pointer jump: one, three
// RQ18 - compare register jump: three, three or four
// RQ19 - compare indirect jump: four or five cycles
// RQ20 - decrement jumps: register 2 2/3, direct 3 3/4
// RQ21 - multiply four cycles, divide eight cycles
// RQ22 - calls, jumps and returns: fixed lengths, cycles
// RQ23 - relative offset signed, from next instruction
// RQ24 - unused opcode behaves as no operation
// RQ25 - page targets stay in 2 kB page
`ifndef ITD_MAP_SVH
`define ITD_MAP_SVH

// ==========================================================
// encoded lengths in bytes
`define ITD_LEN_1B       2'h1
`define ITD_LEN_2B       2'h2
`define ITD_LEN_3B       2'h3

// ==========================================================
// execution times in system clock cycles
`define ITD_CYC_SINGLE   4'h1
`define ITD_CYC_DOUBLE   4'h2
`define ITD_CYC_TRIPLE   4'h3
`define ITD_CYC_MUL      4'h4
`define ITD_CYC_LONG     4'h4
`define ITD_CYC_CJNE_IND 4'h4
`define ITD_CYC_RET      4'h5
`define ITD_CYC_DIV      4'h8
`define ITD_CYC_TAKEN    4'h1

// ==========================================================
// special opcodes
`define ITD_OP_NOP       8'h00
`define ITD_OP_UNUSED    8'ha5
`define ITD_OP_MUL       8'ha4
`define ITD_OP_DIV       8'h84

// ==========================================================
// address layout of page targets
`define ITD_PAGE_MSB     15
`define ITD_PAGE_LSB     11

`endif

// ===== itd_pkg.sv
// types shared by the instruction timing decoder files
package itd_pkg;

  // where a branch or call finds its destination
  typedef enum logic [2:0] {
    ITD_TS_NONE     = 3'h0,
    ITD_TS_REL1     = 3'h1,
    ITD_TS_REL2     = 3'h2,
    ITD_TS_PAGE     = 3'h3,
    ITD_TS_LONG     = 3'h4,
    ITD_TS_ACC_DATA_POINTER_16 = 3'h5,
    ITD_TS_RET      = 3'h6
  } itd_tsel_t;

  // execution sequencer, gray along idle, run, last
  typedef enum logic [1:0] {
    ITD_ST_IDLE = 2'h0,
    ITD_ST_RUN  = 2'h1,
    ITD_ST_LAST = 2'h3
  } itd_state_t;

  // decoded shape of one opcode
  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cyc;
    logic       cond;
    itd_tsel_t  tsel;
  } itd_dec_t;

endpackage : itd_pkg

// ===== itd_prog_mem.sv
// program memory model serving the three instruction bytes at a pc
`timescale 1ns/1ps
module itd_prog_mem (
  input  wire logic        sys_clk,
  input  wire logic        fetch_en,
  input  wire logic [15:0] fetch_pc,
  output logic [7:0]       byte0,
  output logic [7:0]       byte1,
  output logic [7:0]       byte2
);
  logic [7:0] mem [0:256-1];
  logic [7:0] junk_r = 8'h5a;

  // ==========================================================
  // idle bus
  // an idle bus moves every cycle so a stale byte cannot pass for data
  always_ff @(posedge sys_clk) begin
    junk_r <= junk_r + 8'h3b;
  end

  // read port, the index wraps inside the 256 byte window
  always_comb begin
    byte0 = fetch_en ? mem[fetch_pc[7:0]] : junk_r;
    byte1 = fetch_en ? mem[fetch_pc[7:0] + 8'h01] : ~junk_r;
    byte2 = fetch_en ? mem[fetch_pc[7:0] + 8'h02] : junk_r ^ 8'h96;
  end
endmodule : itd_prog_mem

// ===== itd_target_calc.sv
// next instruction address and branch destination arithmetic
`timescale 1ns/1ps
`include "itd_map.svh"
module itd_target_calc (
  input  wire logic [15:0]      instr_pc,
  input  wire logic [1:0]       len,
  input  wire itd_pkg::itd_tsel_t tsel,
  input  wire logic [7:0]       opcode,
  input  wire logic [7:0]       operand1,
  input  wire logic [7:0]       operand2,
  input  wire logic [7:0]       acc,
  input  wire logic [15:0]      data_pointer_16,
  input  wire logic [15:0]      return_addr,
  output logic [15:0]           next_pc,
  output logic [15:0]           target
);
  logic [7:0]  rel;

  // ========================================================
  // relative offsets count from the following instruction
  always_comb begin
    next_pc = instr_pc + {14'h0, len};
    rel     = (tsel == itd_pkg::ITD_TS_REL2) ? operand2 : operand1;
    unique case (tsel)
      // RQ23 signed offset
      itd_pkg::ITD_TS_REL1,
      itd_pkg::ITD_TS_REL2: target = next_pc + {{8{rel[7]}}, rel};
      // RQ25 same page
      itd_pkg::ITD_TS_PAGE: target = {
        next_pc[`ITD_PAGE_MSB:`ITD_PAGE_LSB], opcode[7:5], operand1};
      itd_pkg::ITD_TS_LONG: target = {operand1, operand2};
      // RQ17 accumulator plus pointer
      itd_pkg::ITD_TS_ACC_DATA_POINTER_16: target = data_pointer_16 + {8'h0, acc};
      itd_pkg::ITD_TS_RET:      target = return_addr;
      default:                  target = next_pc;
    endcase
  end
endmodule : itd_target_calc

// ===== tb_top.sv
// self-checking bench for the instruction timing decoder
`timescale 1ns/1ps
module tb_top;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        instr_valid = 1'b0;
  logic [15:0] instr_pc = 16'h0000;
  logic [7:0]  acc = 8'h00;
  logic [15:0] data_pointer_16 = 16'h0000;
  logic [15:0] return_addr = 16'h0000;
  logic        cond_true = 1'b0;
  logic [1:0]  cur_len = 2'h1;
  logic [7:0]  opcode, operand1, operand2, b1, b2;
  logic        issue_ready, exec_busy, exec_done, redirect, nop_alias;
  logic [1:0]  instr_len;
  logic [3:0]  instr_cycles;
  logic [15:0] next_pc, redirect_target;
  logic [31:0] seed = 32'h4a694586;
  int          failures = 0;
  int          tests_run = 0;
  // opcode, length, cycles, taken cycles, destination kind
  logic [23:0] tbl [0:56] = '{
    24'h281100, 24'h381100, 24'h981100, 24'h252200, 24'h242200,
    24'h261200, 24'h061200, 24'h161200, 24'h533300, 24'h433300,
    24'h633300, 24'h522200, 24'he41100, 24'hf41100, 24'h231100,
    24'h331100, 24'h031100, 24'h131100, 24'hc41100, 24'h853300,
    24'h903300, 24'h931300, 24'h831300, 24'he21300, 24'hf21300,
    24'he01300, 24'hf01300, 24'hc02200, 24'hd02200, 24'hd61200,
    24'h822200, 24'hb02200, 24'h722200, 24'ha02200, 24'h402231,
    24'h502231, 24'h602231, 24'h702231, 24'h103342, 24'h203342,
    24'h303342, 24'h802301, 24'h731305, 24'hb83342, 24'hb63452,
    24'hd82231, 24'hd53342, 24'ha41400, 24'h841800, 24'h112303,
    24'h012303, 24'h123404, 24'h023404, 24'h221506, 24'h321506,
    24'ha51100, 24'h001100};

  // ==========================================================
  // clock, far side and device
  always #4 sys_clk = ~sys_clk;
  // absent bytes are presented as zero
  assign operand1 = (cur_len > 2'h1) ? b1 : 8'h00;
  assign operand2 = (cur_len > 2'h2) ? b2 : 8'h00;
  itd_prog_mem u_mem (.sys_clk(sys_clk), .fetch_en(instr_valid),
    .fetch_pc(instr_pc), .byte0(opcode), .byte1(b1), .byte2(b2));
  itd_decoder u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .instr_valid(instr_valid), .opcode(opcode), .operand1(operand1),
    .operand2(operand2), .instr_pc(instr_pc), .acc(acc),
    .data_pointer_16(data_pointer_16), .return_addr(return_addr),
    .cond_true(cond_true), .issue_ready(issue_ready),
    .exec_busy(exec_busy), .exec_done(exec_done), .instr_len(instr_len),
    .instr_cycles(instr_cycles), .next_pc(next_pc), .redirect(redirect),
    .redirect_target(redirect_target), .nop_alias(nop_alias));

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // issue one instruction at a falling edge and follow it to done;
  // back leaves the bench in the done cycle for a back-to-back issue
  task automatic run_one(int idx, bit back, logic [15:0] pc,
                         logic [7:0] o1, logic [7:0] o2);
    logic [23:0] e;
    logic [15:0] np, tg;
    logic [31:0] r;
    logic [3:0]  n;
    logic        rd;
    e = tbl[idx];
    r = rnd();
    u_mem.mem[pc[7:0]] = e[23:16];
    u_mem.mem[pc[7:0] + 8'h01] = o1;
    u_mem.mem[pc[7:0] + 8'h02] = o2;
    cond_true = r[0];
    acc = r[15:8];
    data_pointer_16 = r[31:16];
    return_addr = 16'(rnd() >> 16);
    instr_pc = pc;
    cur_len = e[13:12];
    instr_valid = 1'b1;
    n = (e[7:4] != 4'h0 && cond_true) ? e[7:4] : e[11:8];
    np = pc + {14'h0000, e[13:12]};
    case (e[3:0])
      4'h1: tg = np + {{8{o1[7]}}, o1};
      4'h2: tg = np + {{8{o2[7]}}, o2};
      4'h3: tg = {np[15:11], e[23:21], o1};
      4'h4: tg = {o1, o2};
      4'h5: tg = data_pointer_16 + {8'h00, acc};
      4'h6: tg = return_addr;
      default: tg = np;
    endcase
    rd = (e[3:0] != 4'h0) && (e[7:4] == 4'h0 || cond_true);
    check("issue_ready", 16'(issue_ready), 16'h1);
    @(posedge sys_clk);
    @(negedge sys_clk);
    if (!back || n != 4'h1) instr_valid = 1'b0;
    for (int k = 1; k <= n; k++) begin
      check("exec_done", 16'(exec_done), 16'(k == n));
      check("issue_ready", 16'(issue_ready), 16'(k == n));
      check("exec_busy", 16'(exec_busy), 16'h1);
      if (k < n) @(negedge sys_clk);
    end
    check("instr_len", 16'(instr_len), 16'(e[13:12]));
    check("instr_cycles", 16'(instr_cycles), 16'(n));
    check("next_pc", next_pc, np);
    check("redirect", 16'(redirect), 16'(rd));
    check("target", redirect_target, rd ? tg : np);
    check("nop_alias", 16'(nop_alias), 16'(e[23:16] == 8'ha5));
    if (!back) begin
      @(negedge sys_clk);
      check("done_idle", 16'(exec_done), 16'h0);
      check("busy_idle", 16'(exec_busy), 16'h0);
    end
  endtask : run_one

  // ==========================================================
  // watchdog, far beyond the roughly 1200 cycles the run needs
  initial begin
    #(8 * 20000);
    failures++;
    close_out();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(negedge sys_clk);
    check("ready_rst", 16'(issue_ready), 16'h1);
    check("busy_rst", 16'(exec_busy), 16'h0);
    check("len_rst", 16'(instr_len), 16'h0);
    sys_rst = 1'b0;
    // each of the 57 table entries once, first issue right after release
    for (int i = 0; i < 57; i++) run_one(i, 1'b0, 16'(rnd() >> 16),
                                         8'h5c, 8'hc3);
    // page crossing, extreme offsets, wrap of the address space
    run_one(50, 1'b0, 16'h07fe, 8'h34, 8'h00);
    run_one(41, 1'b0, 16'h0010, 8'h80, 8'h00);
    run_one(46, 1'b0, 16'hfffd, 8'h00, 8'h7f);
    // back to back after the longest and the shortest instructions
    run_one(48, 1'b1, 16'h0100, 8'h00, 8'h00);
    run_one(0, 1'b1, 16'h0101, 8'h00, 8'h00);
    run_one(12, 1'b0, 16'h0102, 8'h00, 8'h00);
    repeat (300) run_one(rnd() % 57, 1'(rnd()), 16'(rnd() >> 16),
                         8'(rnd() >> 24), 8'(rnd() >> 24));
    run_one(56, 1'b0, 16'h0200, 8'h00, 8'h00);
    // a second reset in the middle of a divide clears everything
    u_mem.mem[8'h00] = 8'h84;
    instr_pc = 16'h0000;
    cur_len = 2'h1;
    instr_valid = 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    instr_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("busy_div", 16'(exec_busy), 16'h1);
    sys_rst = 1'b1;
    @(negedge sys_clk);
    check("busy_rst2", 16'(exec_busy), 16'h0);
    check("ready_rst2", 16'(issue_ready), 16'h1);
    sys_rst = 1'b0;
    run_one(3, 1'b0, 16'h0040, 8'h11, 8'h00);
    close_out();
  end
endmodule : tb_top
